//--- frs_top.sv
// frs_top: fault-driven shutdown and resequence of rail groups
// assumes rail monitors give synchronous off/good/fault levels and pulses
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module frs_top
   import frs_pkg::*;
#(
   parameter int RAILS = NUM_RAILS,
   parameter int STEP_CYCLES = STEP_CYC,
   parameter int STABLE_CYCLES = STABLE_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [RAILS-1:0] rail_fault,
   input wire logic [RAILS-1:0] rail_good,
   input wire logic [RAILS-1:0] rail_below_floor,
   input wire logic [RAILS-1:0] rail_has_monitor,
   input wire logic [RAILS-1:0] off_timer_expired,
   input wire logic [RAILS-1:0] logic_out,
   output logic [RAILS-1:0] seq_off_req,
   output logic [RAILS-1:0] seq_on_req,
   output logic [RAILS-1:0] shutdown_overtime_warning,
   output logic [RAILS-1:0] general_output_pin,
   output logic reseq_error,
   output logic reseq_busy
);
   ////////////////////////////////////////////////////////////////////////
   logic [31:0] ctrl_ff;
   logic [RAILS-1:0] slaves_ff [RAILS];
   logic [3:0] retry_ff;
   logic [2*RAILS-1:0] outcfg_ff;
   logic [RAILS-1:0] group_ff;
   logic [2:0] att_ff;
   logic err_ff;
   logic [31:0] cnt_ff;
   logic [7:0] dly_steps_ff;
   logic [RAILS-1:0] cmd_group;
   logic cmd_go;
   frs_state_e state_ff, nxt_state;
   wire wr = psel & penable & pwrite;
   // read data is captured in the setup cycle so it stands at the access edge
   wire rd = psel & ~penable & ~pwrite;
   wire [7:0] slave_idx_sel = pwdata[31:24];
   wire en = ctrl_ff[CTRL_EN_BIT];
   wire cont_on_err = ctrl_ff[CTRL_CONT_BIT];
   wire [7:0] dly_cfg = ctrl_ff[CTRL_DLY_LSB +: 8];
   wire [2:0] lim_cfg = ctrl_ff[CTRL_LIM_LSB +: 3];
   wire addr_ok = (paddr == REG_CTRL) | (paddr == REG_SLAVES) | (paddr == REG_RETRY) |
                  (paddr == REG_OUTCFG) | (paddr == REG_STATUS) | (paddr == REG_CMD) |
                  (paddr == REG_GROUP);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   ////////////////////////////////////////////////////////////////////////
   logic [RAILS-1:0] exhausted;
   frs_retry_tracker #(.RAILS(RAILS)) u_retry (
      .core_clk(core_clk),
      .rst(rst),
      .fault_pulse(rail_fault & ~group_ff),
      .rail_good(rail_good),
      .retry_limit(retry_ff),
      .exhausted(exhausted)
   );
   function automatic logic [RAILS-1:0] group_of(input logic [RAILS-1:0] hit);
      logic [RAILS-1:0] acc;
      acc = '0;
      for (int i = 0; i < RAILS; i++) begin
         if (hit[i]) begin
            acc = acc | slaves_ff[i] | (RAILS'(1) << i);
         end
      end
      return acc;
   endfunction
   wire [RAILS-1:0] new_group = group_of(exhausted) | (cmd_go ? cmd_group : '0);
   wire join_req = en & (|(new_group & ~group_ff));
   wire [RAILS-1:0] all_group = group_ff | new_group;
   wire all_off = &(rail_below_floor | ~all_group);
   wire all_good = &(rail_good | ~group_ff);
   wire [RAILS-1:0] ovt = off_timer_expired & ~rail_below_floor & seq_off_req;
   wire any_ovt = |(ovt & group_ff);
   wire limit_hit = (lim_cfg != LIM_UNLIMITED) && (att_ff >= lim_cfg);
   wire dly_done = (dly_steps_ff == dly_cfg) && (cnt_ff == 32'h0);
   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         FRS_IDLE: begin
            if (join_req) begin
               nxt_state = FRS_OFF;
            end
         end
         FRS_OFF: begin
            if (any_ovt && !cont_on_err) begin
               nxt_state = FRS_HALT;
            end else if (all_off) begin
               nxt_state = FRS_WAIT;
            end
         end
         FRS_WAIT: begin
            if (join_req) begin
               nxt_state = FRS_OFF;
            end else if (dly_done) begin
               nxt_state = FRS_ON;
            end
         end
         FRS_ON: begin
            if (join_req) begin
               nxt_state = FRS_OFF;
            end else if (all_good) begin
               nxt_state = FRS_STABLE;
            end
         end
         FRS_STABLE: begin
            if (join_req || !all_good) begin
               nxt_state = limit_hit ? FRS_HALT : FRS_OFF;
            end else if (cnt_ff == 32'(STABLE_CYCLES - 1)) begin
               nxt_state = FRS_IDLE;
            end
         end
         FRS_HALT: begin
            if (cmd_go) begin
               nxt_state = FRS_IDLE;
            end
         end
         default: nxt_state = FRS_IDLE;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_ff <= FRS_IDLE;
         group_ff <= '0;
         att_ff <= 3'h0;
         err_ff <= 1'b0;
         cnt_ff <= 32'h0;
         dly_steps_ff <= 8'h0;
      end else begin
         state_ff <= nxt_state;
         // leaving halt frees the group too, otherwise a fresh request never starts
         if (nxt_state == FRS_IDLE) begin
            group_ff <= '0;
            att_ff <= 3'h0;
         end else if (join_req && state_ff != FRS_HALT) begin
            // a merged group inherits the running attempt count
            group_ff <= all_group;
         end
         // every fresh off-wait-on pass counts as one attempt
         if (nxt_state == FRS_OFF && (state_ff == FRS_STABLE || state_ff == FRS_IDLE)) begin
            att_ff <= att_ff + 3'h1;
         end
         if (state_ff == FRS_OFF && any_ovt) begin
            err_ff <= 1'b1;
         end else if (wr && paddr == REG_STATUS && pwdata[ST_ERR_BIT]) begin
            err_ff <= 1'b0;
         end
         if (state_ff != nxt_state) begin
            cnt_ff <= 32'h0;
            dly_steps_ff <= 8'h0;
         end else if (state_ff == FRS_WAIT && !dly_done) begin
            if (cnt_ff == 32'(STEP_CYCLES - 1) && dly_steps_ff != dly_cfg) begin
               cnt_ff <= 32'h0;
               dly_steps_ff <= dly_steps_ff + 8'h1;
            end else if (dly_steps_ff != dly_cfg) begin
               cnt_ff <= cnt_ff + 32'h1;
            end
         end else if (state_ff == FRS_STABLE) begin
            cnt_ff <= cnt_ff + 32'h1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // soft off for every rail in the group, no hard kill path exists
   assign seq_off_req = (state_ff == FRS_OFF || state_ff == FRS_WAIT || state_ff == FRS_HALT) ?
                        group_ff : '0;
   assign seq_on_req = (state_ff == FRS_ON || state_ff == FRS_STABLE) ? group_ff : '0;
   assign shutdown_overtime_warning = ovt;
   assign reseq_error = err_ff;
   assign reseq_busy = (state_ff != FRS_IDLE);
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         general_output_pin <= '0;
      end else begin
         for (int i = 0; i < RAILS; i++) begin
            if (!rail_has_monitor[i] && outcfg_ff[2*i+1]) begin
               general_output_pin[i] <= seq_on_req[i];
            end else begin
               general_output_pin[i] <= outcfg_ff[2*i] ? logic_out[i] : outcfg_ff[RAILS+i];
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl_ff <= CTRL_RST;
         retry_ff <= 4'h0;
         outcfg_ff <= '0;
         cmd_go <= 1'b0;
         cmd_group <= '0;
         for (int i = 0; i < RAILS; i++) begin
            slaves_ff[i] <= '0;
         end
      end else begin
         cmd_go <= wr && paddr == REG_CMD;
         if (wr && paddr == REG_CMD) begin
            cmd_group <= pwdata[RAILS-1:0];
         end
         if (wr && paddr == REG_CTRL) begin
            ctrl_ff <= pwdata;
         end
         if (wr && paddr == REG_RETRY) begin
            retry_ff <= pwdata[3:0];
         end
         if (wr && paddr == REG_OUTCFG) begin
            outcfg_ff <= pwdata[2*RAILS-1:0];
         end
         for (int i = 0; i < RAILS; i++) begin
            if (wr && paddr == REG_SLAVES && slave_idx_sel == 8'(i)) begin
               slaves_ff[i] <= pwdata[RAILS-1:0];
            end
         end
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0;
      end else if (rd) begin
         case (paddr)
            REG_CTRL: prdata <= ctrl_ff;
            REG_RETRY: prdata <= {28'h0, retry_ff};
            REG_OUTCFG: prdata <= 32'(outcfg_ff);
            REG_STATUS: prdata <= {21'h0, att_ff, 1'b0, state_ff, 3'h0, err_ff};
            REG_GROUP: prdata <= 32'(group_ff);
            default: prdata <= 32'h0;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   property p_err_on_ovt;
      @(posedge core_clk) disable iff (rst) (state_ff == FRS_OFF && any_ovt) |=> reseq_error;
   endproperty
   a_err_on_ovt: assert property (p_err_on_ovt) else $error("overtime not reported");
   property p_halt_on_err;
      @(posedge core_clk) disable iff (rst)
         (state_ff == FRS_OFF && any_ovt && !cont_on_err) |=> state_ff == FRS_HALT;
   endproperty
   a_halt_on_err: assert property (p_halt_on_err) else $error("did not stop on overtime");
   property p_on_needs_off;
      @(posedge core_clk) disable iff (rst) (state_ff == FRS_OFF && nxt_state == FRS_WAIT) |-> all_off;
   endproperty
   a_on_needs_off: assert property (p_on_needs_off) else $error("left shutdown early");
   property p_soft_off;
      @(posedge core_clk) disable iff (rst) (state_ff == FRS_OFF) |-> seq_off_req == group_ff;
   endproperty
   a_soft_off: assert property (p_soft_off) else $error("group not sequenced off");
   property p_limit;
      @(posedge core_clk) disable iff (rst)
         (lim_cfg != LIM_UNLIMITED && state_ff == FRS_OFF) |-> att_ff <= lim_cfg;
   endproperty
   a_limit: assert property (p_limit) else $error("attempt limit exceeded");
   property p_group_keeps;
      @(posedge core_clk) disable iff (rst)
         (state_ff == FRS_OFF && $past(state_ff) == FRS_OFF) |-> ((group_ff & $past(group_ff)) == $past(group_ff));
   endproperty
   a_group_keeps: assert property (p_group_keeps) else $error("group shrank");
   property p_stable_clear;
      @(posedge core_clk) disable iff (rst) (state_ff == FRS_STABLE && nxt_state == FRS_IDLE) |=> att_ff == 3'h0;
   endproperty
   a_stable_clear: assert property (p_stable_clear) else $error("counter not cleared");
   property p_wait_min;
      @(posedge core_clk) disable iff (rst) (state_ff == FRS_WAIT && nxt_state == FRS_ON) |-> dly_steps_ff == dly_cfg;
   endproperty
   a_wait_min: assert property (p_wait_min) else $error("delay cut short");
   sequence s_enter_wait;
      state_ff == FRS_OFF ##1 state_ff == FRS_WAIT;
   endsequence
   sequence s_wait_fresh;
      dly_steps_ff == 8'h0 && cnt_ff == 32'h0;
   endsequence
   property p_wait_entry;
      @(posedge core_clk) disable iff (rst) s_enter_wait |-> s_wait_fresh;
   endproperty
   a_wait_entry: assert property (p_wait_entry) else $error("delay did not start from zero");
   property p_group_fault_ignored;
      @(posedge core_clk) disable iff (rst) (state_ff != FRS_IDLE) |-> ((exhausted & group_ff) == '0);
   endproperty
   a_group_fault_ignored: assert property (p_group_fault_ignored) else $error("group fault escalated");
endmodule

//--- frs_pkg.sv
// frs_pkg: constants for the fault resequence controller
// assumes a 100 MHz core clock and a 32-bit apb register port
package frs_pkg;
   localparam int NUM_RAILS = 10;
   localparam int CLK_MHZ = 100;
   // timing
   localparam int DELAY_STEP_MS = 5;
   localparam int DELAY_MAX_MS = 1275;
   localparam int STABLE_MS = 1000;
   localparam int CYC_PER_MS = CLK_MHZ * 1000;
   localparam int STEP_CYC = DELAY_STEP_MS * CYC_PER_MS;
   localparam int STABLE_CYC = STABLE_MS * CYC_PER_MS;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_SLAVES = 8'h04;
   localparam logic [7:0] REG_RETRY = 8'h08;
   localparam logic [7:0] REG_OUTCFG = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_CMD = 8'h14;
   localparam logic [7:0] REG_GROUP = 8'h18;
   // ctrl fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_CONT_BIT = 1;
   localparam int CTRL_DLY_LSB = 8;
   localparam int CTRL_LIM_LSB = 16;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [2:0] LIM_UNLIMITED = 3'h0;
   // status fields
   localparam int ST_ERR_BIT = 0;
   localparam int ST_STATE_LSB = 4;
   localparam int ST_CNT_LSB = 8;
   typedef enum logic [2:0] {
      FRS_IDLE = 3'b000,
      FRS_OFF = 3'b001,
      FRS_WAIT = 3'b010,
      FRS_ON = 3'b011,
      FRS_STABLE = 3'b100,
      FRS_HALT = 3'b101
   } frs_state_e;
endpackage

//--- frs_retry_tracker.sv
// frs_retry_tracker: per-rail retry exhaustion tracker
// assumes faults are single-cycle pulses and rail_good is a level from the rail monitors
`timescale 1ns/1ps
module frs_retry_tracker #(
   parameter int RAILS = 10
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [RAILS-1:0] fault_pulse,
   input wire logic [RAILS-1:0] rail_good,
   input wire logic [3:0] retry_limit,
   output logic [RAILS-1:0] exhausted
);
   logic [3:0] cnt_ff [RAILS];
   wire [RAILS-1:0] done_vec;
   genvar g;
   // a fault only escalates once the configured retries are spent
   assign exhausted = fault_pulse & done_vec;
   generate
      for (g = 0; g < RAILS; g++) begin : g_rail
         assign done_vec[g] = (cnt_ff[g] >= retry_limit);
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               cnt_ff[g] <= 4'h0;
            end else if (fault_pulse[g] && !done_vec[g]) begin
               cnt_ff[g] <= cnt_ff[g] + 4'h1;
            end else if (exhausted[g] || (rail_good[g] && !fault_pulse[g])) begin
               cnt_ff[g] <= 4'h0;
            end
         end
      end
   endgenerate
endmodule

//--- frs_rail_model.sv
// frs_rail_model: behavioural supply rails behind the sequencer enables
// assumes one clock domain and level off/on requests from the controller
`timescale 1ns/1ps
module frs_rail_model #(
   parameter int RAILS = 10,
   parameter int DLY = 8,
   parameter int SLOW = 40,
   parameter int LIM = 20
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [RAILS-1:0] seq_off_req,
   input wire logic [RAILS-1:0] seq_on_req,
   input wire logic slow_off,
   input wire logic [RAILS-1:0] fault,
   output logic [RAILS-1:0] rail_good,
   output logic [RAILS-1:0] rail_below_floor,
   output logic [RAILS-1:0] off_timer_expired
);
   int cnt [RAILS];
   ////////////////////////////////////////////////////////////////////////
   // rails ramp, so an instant response would hide ordering slips
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rail_good <= '1;
         rail_below_floor <= '0;
         off_timer_expired <= '0;
         for (int i = 0; i < RAILS; i++) cnt[i] <= 0;
      end else begin
         for (int i = 0; i < RAILS; i++) begin
            cnt[i] <= cnt[i] + 1;
            if (seq_on_req[i]) begin
               rail_below_floor[i] <= 1'b0;
               off_timer_expired[i] <= 1'b0;
               if (cnt[i] >= DLY) rail_good[i] <= 1'b1;
            end else if (seq_off_req[i]) begin
               rail_good[i] <= 1'b0;
               if (cnt[i] >= (slow_off ? SLOW : DLY)) rail_below_floor[i] <= 1'b1;
               if (slow_off && cnt[i] >= LIM) off_timer_expired[i] <= 1'b1;
            end else begin
               // released rails drop their stale off-phase flags
               cnt[i] <= 0;
               rail_below_floor[i] <= 1'b0;
               off_timer_expired[i] <= 1'b0;
            end
            // a faulted rail loses regulation until it is ramped again
            if (fault[i]) begin
               rail_good[i] <= 1'b0;
               cnt[i] <= 0;
            end
         end
      end
   end
endmodule

//--- frs_tb.sv
// tb: self-checking bench for frs_top, rail model on the far side
// assumes zero-wait apb slave and shortened step and stable counts
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
`define WAIT_UNTIL(c, n) for (int k = 0; k < (n) && !(c); k++) @(negedge core_clk);
module tb;
   import frs_pkg::*;
   localparam int STEP = 10;
   localparam int STAB = 50;
   localparam logic [9:0] GRP = 10'h0A4;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow_off = 1'b0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, cfg;
   logic pready, pslverr, reseq_error, reseq_busy;
   logic [9:0] rail_fault = '0, logic_out = '0, rail_good, rail_below_floor, off_timer_expired;
   logic [9:0] seq_off_req, seq_on_req, shutdown_overtime_warning, general_output_pin, exp_pin, has_mon;
   logic [32:0] exp_q[$], msk_q[$], e, m;
   int mismatches = 0, n_checks = 0, cyc = 0, n;
   always #5 core_clk = ~core_clk;
   frs_top #(.RAILS(10), .STEP_CYCLES(STEP), .STABLE_CYCLES(STAB)) uut (.core_clk(core_clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rail_fault(rail_fault), .rail_good(rail_good),
      .rail_below_floor(rail_below_floor), .rail_has_monitor(has_mon), .off_timer_expired(off_timer_expired),
      .logic_out(logic_out), .seq_off_req(seq_off_req), .seq_on_req(seq_on_req),
      .shutdown_overtime_warning(shutdown_overtime_warning), .general_output_pin(general_output_pin),
      .reseq_error(reseq_error), .reseq_busy(reseq_busy));
   frs_rail_model #(.RAILS(10)) rails (.core_clk(core_clk), .rst(rst), .seq_off_req(seq_off_req),
      .seq_on_req(seq_on_req), .slow_off(slow_off), .fault(rail_fault), .rail_good(rail_good),
      .rail_below_floor(rail_below_floor), .off_timer_expired(off_timer_expired));
   ///////////////////////////////////////////////////////////////////////////
   // one word per call; reads queue {pslverr, prdata} masked expectations
   task automatic apb(input logic w, input logic [7:0] a, input logic [32:0] d, input logic [32:0] mk);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d[31:0];
      if (!w) begin
         exp_q.push_back(d & mk);
         msk_q.push_back(mk);
      end
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // pin i follows its sequenced enable, the logic block or the host level bit
   function automatic logic [9:0] pin_exp(input logic [31:0] c, input logic [9:0] mon, lo, on);
      logic [9:0] r;
      for (int i = 0; i < 10; i++) r[i] = (!mon[i] && c[2*i+1]) ? on[i] : (c[2*i] ? lo[i] : c[10+i]);
      return r;
   endfunction
   task automatic pulse(input logic [9:0] f);
      @(posedge core_clk);
      rail_fault <= f;
      @(posedge core_clk);
      rail_fault <= '0;
   endtask
   task automatic final_report;
      if (mismatches == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   ///////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         `CHK({pslverr, prdata} & m, e)
      end
   end
   // whole run is well under a thousand cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         final_report();
      end
   end
   ///////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(70));
      logic_out = 10'($urandom());
      has_mon = 10'($urandom());
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      apb(1'b0, REG_STATUS, 33'h0, 33'h1_0000_0771);
      apb(1'b0, 8'h1C, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
      apb(1'b1, REG_CTRL, 33'h0_0002_0301, 33'h0);
      apb(1'b0, REG_CTRL, 33'h0_0002_0301, 33'h1_FFFF_FFFF);
      apb(1'b1, REG_SLAVES, 33'h0_0200_00A0, 33'h0);
      apb(1'b1, REG_RETRY, 33'h1, 33'h0);
      cfg = $urandom() & 32'h000F_FFFF;
      apb(1'b1, REG_OUTCFG, {1'b0, cfg}, 33'h0);
      logic_out <= 10'($urandom());
      repeat (3) @(negedge core_clk);
      exp_pin = pin_exp(cfg, has_mon, logic_out, 10'h000);
      `CHK(general_output_pin, exp_pin)
      // first fault only spends the single retry
      pulse(10'h004);
      `WAIT_UNTIL(reseq_busy, 5)
      `CHK(reseq_busy, 1'b0)
      pulse(10'h004);
      `WAIT_UNTIL(reseq_busy, 5)
      `CHK(reseq_busy, 1'b1)
      `CHK(seq_off_req, GRP)
      pulse(10'h020);
      pulse(10'h020);
      apb(1'b0, REG_GROUP, {23'h0, GRP}, 33'h1_0000_03FF);
      `WAIT_UNTIL(&(rail_below_floor | ~GRP), 60)
      n = 0;
      while (seq_on_req === '0 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      `CHK(n >= 3 * STEP && n <= 3 * STEP + 5, 1'b1)
      `WAIT_UNTIL(&(rail_good | ~GRP), 60)
      repeat (STAB - 15) @(negedge core_clk);
      `CHK(general_output_pin, pin_exp(cfg, has_mon, logic_out, GRP))
      apb(1'b0, REG_STATUS, 33'h0_0000_0140, 33'h1_0000_0771);
      repeat (20) @(negedge core_clk);
      apb(1'b0, REG_STATUS, 33'h0, 33'h1_0000_0771);
      // host request, then faults in stable use up the two attempts
      apb(1'b1, REG_CMD, {23'h0, GRP}, 33'h0);
      repeat (2) begin
         `WAIT_UNTIL(!(&(rail_good | ~GRP)), 20)
         `WAIT_UNTIL(&(rail_good | ~GRP), 80)
         repeat (5) @(negedge core_clk);
         pulse(10'h004);
      end
      repeat (5) @(negedge core_clk);
      apb(1'b0, REG_STATUS, 33'h0_0000_0050, 33'h1_0000_0070);
      slow_off <= 1'b1;
      // the first request only leaves halt, the second starts a new pass
      apb(1'b1, REG_CMD, {23'h0, GRP}, 33'h0);
      apb(1'b1, REG_CMD, {23'h0, GRP}, 33'h0);
      `WAIT_UNTIL(reseq_error, 80)
      `CHK(reseq_error, 1'b1)
      `CHK(shutdown_overtime_warning != '0 && (shutdown_overtime_warning & ~GRP) == '0, 1'b1)
      repeat (60) @(negedge core_clk);
      apb(1'b0, REG_STATUS, 33'h0_0000_0051, 33'h1_0000_0071);
      final_report();
   end
endmodule
